// ---- common/fpsr_pkg.sv ----
// fault plane and status register block: shared register map and field layout
// assumes a single system clock; the serial bus pins are sampled, never used as clocks
package fpsr_pkg;

    // ------------------------------------------------------------------
    // register map (command byte values)
    // ------------------------------------------------------------------
    localparam logic [7:0] FPSR_ADDR_UV_STATUS   = 8'hD8;
    localparam logic [7:0] FPSR_ADDR_OV_STATUS   = 8'hD9;
    localparam logic [7:0] FPSR_ADDR_SFD_STATUS  = 8'hDA;
    localparam logic [7:0] FPSR_ADDR_GW_STATUS   = 8'hDB;
    localparam logic [7:0] FPSR_ADDR_PLANE_SUP   = 8'hDC;
    localparam logic [7:0] FPSR_ADDR_PLANE_INP   = 8'hDD;
    localparam logic [7:0] FPSR_ADDR_DRV_LOW     = 8'hDE;
    localparam logic [7:0] FPSR_ADDR_DRV_HIGH    = 8'hDF;
    localparam logic [7:0] FPSR_ADDR_MASK_SUP    = 8'hE0;
    localparam logic [7:0] FPSR_ADDR_MASK_INP    = 8'hE1;

    // ------------------------------------------------------------------
    // widths and field layout
    // ------------------------------------------------------------------
    localparam int         FPSR_NUM_SUPPLY   = 7;
    localparam int         FPSR_NUM_GPI      = 4;
    localparam int         FPSR_NUM_DRV      = 9;
    localparam int         FPSR_PLANE_W      = FPSR_NUM_SUPPLY + FPSR_NUM_GPI + 1;
    localparam int         FPSR_INP_W        = FPSR_NUM_GPI + 1;
    localparam int         FPSR_DRV_LOW_W    = 8;
    localparam logic [7:0] FPSR_RESET_VALUE  = 8'h00;
    localparam logic [7:0] FPSR_UNMAPPED_VAL = 8'h00;
    localparam logic [3:0] FPSR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] FPSR_LAST_TX_BIT  = 4'h7;

    // default 7-bit bus address of the block; arbitrary value
    localparam logic [6:0] FPSR_DEFAULT_DEV_ADDR = 7'h34;

    // ------------------------------------------------------------------
    // serial engine states
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ACK_ADDR = 9'h004,
        ST_CMD      = 9'h008,
        ST_ACK_CMD  = 9'h010,
        ST_WDATA    = 9'h020,
        ST_RDATA    = 9'h040,
        ST_RACK     = 9'h080,
        ST_RMORE    = 9'h100
    } fpsr_state_type;

endpackage

// ---- core/fpsr_sync.sv ----
// fpsr_sync: multi-bit level synchroniser
// assumes each bit is an independent level; no bus coherency is promised across bits
module fpsr_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("fpsr_sync needs at least two stages");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("fpsr_sync needs a width of at least one");
    end

    // ------------------------------------------------------------------
    // flop chain, first stage feeds only the next stage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] stage_reg [STAGES];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            stage_reg[0] <= async_in;
            for (int i = 1; i < STAGES; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign sync_out = stage_reg[STAGES-1];

endmodule // fpsr_sync

// ---- core/fpsr_regs.sv ----
// fpsr_regs: fault plane, error masks and read-only status registers behind a serial bus slave
// assumes detector, input and driver levels arrive asynchronously; scl and sda are pins
// sampled by the system clock, which must run well above the bus bit rate

module fpsr_regs
    import fpsr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR    = FPSR_DEFAULT_DEV_ADDR,
    parameter int         SYNC_STAGES = 2
) (
    input  wire logic                       clock,
    input  wire logic                       rstn,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire logic [FPSR_NUM_SUPPLY-1:0] undervoltage_compare,
    input  wire logic [FPSR_NUM_SUPPLY-1:0] overvoltage_compare,
    input  wire logic [FPSR_NUM_SUPPLY-1:0] supply_fault_detector,
    input  wire logic [FPSR_NUM_GPI-1:0]    general_purpose_input,
    input  wire logic                       watchdog_detector_input,
    input  wire logic [FPSR_NUM_DRV-1:0]    programmable_driver_output
);

    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    localparam int SYNC_W = 2 + 3 * FPSR_NUM_SUPPLY + FPSR_INP_W + FPSR_NUM_DRV;

    logic [SYNC_W-1:0]          sync_in;
    logic [SYNC_W-1:0]          sync_q;
    logic                       scl_s;
    logic                       sda_s;
    logic [FPSR_NUM_SUPPLY-1:0] uv_s;
    logic [FPSR_NUM_SUPPLY-1:0] ov_s;
    logic [FPSR_NUM_SUPPLY-1:0] sfd_s;
    logic [FPSR_INP_W-1:0]      inp_s;
    logic [FPSR_NUM_DRV-1:0]    drv_s;

    assign sync_in = {scl_in, sda_in, undervoltage_compare, overvoltage_compare,
                      supply_fault_detector, watchdog_detector_input,
                      general_purpose_input, programmable_driver_output};

    fpsr_sync #(
        .WIDTH  (SYNC_W),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (sync_in),
        .sync_out (sync_q)
    );

    assign {scl_s, sda_s, uv_s, ov_s, sfd_s, inp_s, drv_s} = sync_q;

    // ------------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------------
    logic [FPSR_NUM_SUPPLY-1:0] uv_status_reg;
    logic [FPSR_NUM_SUPPLY-1:0] ov_status_reg;
    logic [FPSR_NUM_SUPPLY-1:0] sfd_status_reg;
    logic [FPSR_INP_W-1:0]      gw_status_reg;
    logic [FPSR_NUM_DRV-1:0]    drv_status_reg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            uv_status_reg  <= '0;
            ov_status_reg  <= '0;
            sfd_status_reg <= '0;
            gw_status_reg  <= '0;
            drv_status_reg <= '0;
        end else begin
            uv_status_reg  <= uv_s;
            ov_status_reg  <= ov_s;
            sfd_status_reg <= sfd_s;
            gw_status_reg  <= inp_s;
            drv_status_reg <= drv_s;
        end
    end

    // ------------------------------------------------------------------
    // bus condition detection
    // ------------------------------------------------------------------
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_prev_reg;
    assign scl_fall   = ~scl_s & scl_prev_reg;
    assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // ------------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------------
    fpsr_state_type state_reg;
    logic [3:0]     bit_cnt_reg;
    logic [7:0]     shift_reg;
    logic [7:0]     tx_reg;
    logic [7:0]     pointer_reg;
    logic           rw_reg;
    logic           oe_reg;
    logic [7:0]     rd_data;
    logic           rd_fire;
    logic           wr_fire;
    logic           byte_done;

    assign byte_done = scl_fall && (bit_cnt_reg == FPSR_BITS_PER_BYTE);
    // read strobe coincides with the byte load so no plane event slips between them
    assign rd_fire = scl_fall && (((state_reg == ST_ACK_ADDR) && rw_reg)
                                  || (state_reg == ST_RMORE));
    assign wr_fire = byte_done && (state_reg == ST_WDATA) && !start_cond && !stop_cond;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
            tx_reg      <= '0;
            pointer_reg <= '0;
            rw_reg      <= 1'b0;
            oe_reg      <= 1'b0;
        end else if (start_cond) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= '0;
            oe_reg      <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= ST_IDLE;
            oe_reg    <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    oe_reg <= 1'b0;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise && (bit_cnt_reg != FPSR_BITS_PER_BYTE)) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_reg <= '0;
                        oe_reg      <= 1'b1;
                        if (state_reg == ST_ADDR) begin
                            rw_reg    <= shift_reg[0];
                            state_reg <= ST_ACK_ADDR;
                            if (shift_reg[7:1] != DEV_ADDR) begin
                                oe_reg    <= 1'b0;
                                state_reg <= ST_IDLE;
                            end
                        end else begin
                            if (state_reg == ST_CMD) begin
                                pointer_reg <= shift_reg;
                            end
                            state_reg <= ST_ACK_CMD;
                        end
                    end
                end
                ST_ACK_ADDR, ST_RMORE: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= '0;
                        if ((state_reg == ST_RMORE) || rw_reg) begin
                            tx_reg    <= rd_data;
                            oe_reg    <= ~rd_data[7];
                            state_reg <= ST_RDATA;
                        end else begin
                            oe_reg    <= 1'b0;
                            state_reg <= ST_CMD;
                        end
                    end
                end
                ST_ACK_CMD: begin
                    if (scl_fall) begin
                        oe_reg    <= 1'b0;
                        state_reg <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == FPSR_LAST_TX_BIT) begin
                            oe_reg    <= 1'b0;
                            state_reg <= ST_RACK;
                        end else begin
                            tx_reg      <= {tx_reg[6:0], 1'b0};
                            oe_reg      <= ~tx_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // a high level at the acknowledge slot ends the read
                    if (scl_rise) begin
                        state_reg <= sda_s ? ST_IDLE : ST_RMORE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    oe_reg    <= 1'b0;
                end
            endcase
        end
    end

    // open drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_reg;

    // ------------------------------------------------------------------
    // error masks
    // ------------------------------------------------------------------
    logic [FPSR_NUM_SUPPLY-1:0] mask_sup_reg;
    logic [FPSR_INP_W-1:0]      mask_inp_reg;
    logic [FPSR_PLANE_W-1:0]    plane_mask;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            mask_sup_reg <= '0;
            mask_inp_reg <= '0;
        end else if (wr_fire) begin
            // the summary position has no mask bit behind it
            if (pointer_reg == FPSR_ADDR_MASK_SUP) begin
                mask_sup_reg <= shift_reg[FPSR_NUM_SUPPLY-1:0];
            end
            if (pointer_reg == FPSR_ADDR_MASK_INP) begin
                mask_inp_reg <= shift_reg[FPSR_INP_W-1:0];
            end
        end
    end

    assign plane_mask = {mask_inp_reg, mask_sup_reg};

    // ------------------------------------------------------------------
    // fault plane
    // ------------------------------------------------------------------
    logic [FPSR_PLANE_W-1:0] live_plane;
    logic [FPSR_PLANE_W-1:0] plane_reg;
    logic [FPSR_PLANE_W-1:0] snapshot_reg;
    logic                    summary_fault_flag_reg;
    logic                    plane_clear;
    logic                    change_vs_snapshot;
    logic                    change_vs_read;

    // masked functions read zero and can never raise the summary
    assign live_plane = {inp_s, sfd_s} & ~plane_mask;
    assign plane_clear = rd_fire && (pointer_reg == FPSR_ADDR_PLANE_INP);
    assign change_vs_snapshot = (live_plane != (snapshot_reg & ~plane_mask));
    // the values just shipped become the reference, so a change during the read survives
    assign change_vs_read = (live_plane != (plane_reg & ~plane_mask));

    always_ff @(posedge clock) begin
        if (!rstn) begin
            summary_fault_flag_reg <= 1'b0;
            plane_reg              <= '0;
            snapshot_reg           <= '0;
        end else if (plane_clear) begin
            snapshot_reg           <= plane_reg;
            summary_fault_flag_reg <= change_vs_read;
            plane_reg              <= live_plane;
        end else if (!summary_fault_flag_reg) begin
            summary_fault_flag_reg <= change_vs_snapshot;
            plane_reg              <= live_plane;
        end
        // summary high and no clear: plane holds the first change
    end

    // ------------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = FPSR_UNMAPPED_VAL;
        unique case (pointer_reg)
            FPSR_ADDR_UV_STATUS: begin
                rd_data = {1'b0, uv_status_reg};
            end
            FPSR_ADDR_OV_STATUS: begin
                rd_data = {1'b0, ov_status_reg};
            end
            FPSR_ADDR_SFD_STATUS: begin
                rd_data = {1'b0, sfd_status_reg};
            end
            FPSR_ADDR_GW_STATUS: begin
                rd_data = {3'h0, gw_status_reg};
            end
            FPSR_ADDR_PLANE_SUP: begin
                rd_data = {summary_fault_flag_reg, plane_reg[FPSR_NUM_SUPPLY-1:0]};
            end
            FPSR_ADDR_PLANE_INP: begin
                rd_data = {3'h0, plane_reg[FPSR_PLANE_W-1:FPSR_NUM_SUPPLY]};
            end
            FPSR_ADDR_DRV_LOW: begin
                rd_data = drv_status_reg[FPSR_DRV_LOW_W-1:0];
            end
            FPSR_ADDR_DRV_HIGH: begin
                rd_data = {7'h00, drv_status_reg[FPSR_NUM_DRV-1]};
            end
            FPSR_ADDR_MASK_SUP: begin
                rd_data = {1'b0, mask_sup_reg};
            end
            FPSR_ADDR_MASK_INP: begin
                rd_data = {3'h0, mask_inp_reg};
            end
            default: begin
                rd_data = FPSR_UNMAPPED_VAL;
            end
        endcase
    end

endmodule // fpsr_regs

// ---- verification/fpsr_regs_asserts.sv ----
// fpsr_regs_asserts: pin-level checks on the serial data driver of fpsr_regs
// assumes scl_in and sda_in carry the resolved wire levels of the bench
module fpsr_regs_asserts #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] idle_cnt;
    logic [7:0] oe_cnt;

    default clocking ck @(posedge clock); endclocking
    default disable iff (!rstn);

    // saturating counts: scl standing high, and length of one drive burst
    always_ff @(posedge clock) begin
        if (!rstn || !scl_in) idle_cnt <= 8'h00;
        else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
    end
    always_ff @(posedge clock) begin
        if (!rstn || !sda_oe) oe_cnt <= 8'h00;
        else if (oe_cnt != 8'hFF) oe_cnt <= oe_cnt + 8'h01;
    end

    AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
        else $error("sda_out not held low");
    AST_OE_RESET: assert property (disable iff (1'b0) !rstn |=> !sda_oe)
        else $error("sda_oe high after a reset cycle");
    AST_OE_FIRST_EDGE: assert property ($rose(rstn) |-> !sda_oe ##1 !sda_oe)
        else $error("sda_oe high right after reset release");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda_oe moved while scl high");
    AST_OE_AFTER_SYNC: assert property (
        $changed(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2))
        else $error("sda_oe moved before scl low passed the synchroniser");
    AST_IDLE_NO_DRIVE: assert property (idle_cnt >= 8'h10 |-> !sda_oe)
        else $error("data driven while bus idle");
    AST_OE_MAX: assert property (oe_cnt <= 8'h78)
        else $error("data driven longer than one byte and acknowledge");
    AST_STOP_RELEASE: assert property (
        scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*4])
        else $error("data driven just after stop");

    COV_ACK: cover property ($rose(sda_oe));
    COV_STOP: cover property (scl_in && $rose(sda_in));
    COV_LONG_DRIVE: cover property (oe_cnt == 8'h60);
endmodule // fpsr_regs_asserts

// ---- verification/fpsr_smbus_host.sv ----
// fpsr_smbus_host: behavioural serial bus controller, 48 ns bit cell
// assumes the bench resolves the data wire with a pull-up against all pull-downs
module fpsr_smbus_host (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // data bits move only with scl low, start and stop move sda with scl high; the clock stands high between frames
    task automatic put_bit(input logic b);
        scl = 1'b0;
        #5.3 sda_pull = ~b;
        #18.7 scl = 1'b1;
        #24;
    endtask
    task automatic get_bit(output logic b);
        scl = 1'b0;
        #5.3 sda_pull = 1'b0;
        #18.7 scl = 1'b1;
        #12 b = sda;
        #12;
    endtask
    task automatic start();
        scl = 1'b0;
        #5.3 sda_pull = 1'b0;
        #18.7 scl = 1'b1;
        #12 sda_pull = 1'b1;
        #12;
    endtask
    task automatic stop();
        scl = 1'b0;
        #5.3 sda_pull = 1'b1;
        #18.7 scl = 1'b1;
        #12 sda_pull = 1'b0;
        #12;
    endtask
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic nb;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(nb);
        ack = ~nb;
    endtask
    task automatic byte_r(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(~more);
    endtask
endmodule // fpsr_smbus_host

// ---- verification/tb_top.sv ----
// tb_top: self-checking bench for fpsr_regs through the serial host model
// assumes the block sits at its default bus address
`define CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) begin \
            failures++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
        end \
    end

module tb_top
    import fpsr_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    localparam int         TIMEOUT = 90000;
    localparam logic [6:0] DEV     = FPSR_DEFAULT_DEV_ADDR;
    localparam logic [7:0] RST_LIST [10] = '{8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC,
                                             8'hDE, 8'hDF, 8'hE0, 8'hE1, 8'hC0};
    localparam logic [7:0] STAT [6] = '{8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDE, 8'hDF};

    int         checks = 0;
    int         failures = 0;
    int         cycles = 0;
    logic       clock;
    logic       rstn;
    logic       scl;
    logic       host_pull;
    wire        sda_wire;
    logic       sda_out;
    logic       sda_oe;
    logic [6:0] uv_in;
    logic [6:0] ov_in;
    logic [6:0] det_in;
    logic [3:0] gp_in;
    logic       wdog_in;
    logic [8:0] drv_in;

    assign sda_wire = ~(host_pull | sda_oe);

    fpsr_smbus_host host (.scl(scl), .sda_pull(host_pull), .sda(sda_wire));

    fpsr_regs uut (
        .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .undervoltage_compare(uv_in),
        .overvoltage_compare(ov_in), .supply_fault_detector(det_in),
        .general_purpose_input(gp_in), .watchdog_detector_input(wdog_in),
        .programmable_driver_output(drv_in)
    );

    function automatic logic [7:0] exp_dc(logic s, logic [11:0] p, logic [11:0] m);
        return {s, p[6:0] & ~m[6:0]};
    endfunction
    function automatic logic [7:0] exp_dd(logic [11:0] p, logic [11:0] m);
        return {3'b000, p[11:7] & ~m[11:7]};
    endfunction
    function automatic logic [7:0] exp_stat(logic [7:0] a);
        case (a)
            FPSR_ADDR_UV_STATUS:  return {1'b0, uv_in};
            FPSR_ADDR_OV_STATUS:  return {1'b0, ov_in};
            FPSR_ADDR_SFD_STATUS: return {1'b0, det_in};
            FPSR_ADDR_GW_STATUS:  return {3'b000, wdog_in, gp_in};
            FPSR_ADDR_DRV_LOW:    return drv_in[7:0];
            FPSR_ADDR_DRV_HIGH:   return {7'h00, drv_in[8]};
            default:              return FPSR_UNMAPPED_VAL;
        endcase
    endfunction

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end
        else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic [2:0] ak;
        host.start();
        host.byte_w({DEV, 1'b0}, ak[2]);
        host.byte_w(a, ak[1]);
        host.start();
        host.byte_w({DEV, 1'b1}, ak[0]);
        host.byte_r(1'b0, d);
        host.stop();
        `CHK("read acks", 3'b111, ak)
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        logic [2:0] ak;
        host.start();
        host.byte_w({DEV, 1'b0}, ak[2]);
        host.byte_w(a, ak[1]);
        host.byte_w(d, ak[0]);
        host.stop();
        `CHK("write acks", 3'b111, ak)
    endtask
    // the inputs register is read only once the summary is seen set, so no
    // change arriving between the two reads is lost
    task automatic log_fault(output logic [7:0] dc, output logic [7:0] dd);
        reg_read(FPSR_ADDR_PLANE_SUP, dc);
        dd = 'x;
        if (dc[7] === 1'b1) reg_read(FPSR_ADDR_PLANE_INP, dd);
    endtask
    // eight cycles cover the synchroniser and plane update latency
    task automatic drive_plane(input logic [11:0] v);
        @(negedge clock);
        det_in = v[6:0];
        gp_in = v[10:7];
        wdog_in = v[11];
        repeat (8) @(negedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            failures++;
            $display("timeout after %0d cycles", cycles);
            complete_run();
        end
    end

    initial begin
        logic [7:0]  d;
        logic [7:0]  dd;
        logic [11:0] p;
        logic [11:0] prev;
        logic [11:0] m;
        logic        ack;
        rstn = 1'b0;
        {uv_in, ov_in, det_in, gp_in, wdog_in, drv_in} = '0;
        p = 12'h000;
        prev = 12'h000;
        void'($urandom(27));
        repeat (20) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        foreach (RST_LIST[i]) begin
            reg_read(RST_LIST[i], d);
            `CHK("reset value", FPSR_RESET_VALUE, d)
        end
        $display("test reset done");
        for (int b = 0; b < 12; b++) begin
            p[b] = ~p[b];
            drive_plane(p);
            log_fault(d, dd);
            `CHK("plane dc", exp_dc(1'b1, p, 12'h000), d)
            `CHK("plane dd", exp_dd(p, 12'h000), dd)
            `CHK("changed bit", 12'h001 << b, {dd[4:0], d[6:0]} ^ prev)
            reg_read(FPSR_ADDR_PLANE_SUP, d);
            `CHK("cleared dc", exp_dc(1'b0, p, 12'h000), d)
            prev = p;
        end
        $display("test plane done");
        p[3] = 1'b0;
        drive_plane(p);
        prev = p;
        p[8] = 1'b0;
        drive_plane(p);
        log_fault(d, dd);
        `CHK("frozen dc", exp_dc(1'b1, prev, 12'h000), d)
        `CHK("frozen dd", exp_dd(prev, 12'h000), dd)
        log_fault(d, dd);
        `CHK("second dc", exp_dc(1'b1, p, 12'h000), d)
        `CHK("second dd", exp_dd(p, 12'h000), dd)
        reg_read(FPSR_ADDR_PLANE_SUP, d);
        `CHK("released dc", exp_dc(1'b0, p, 12'h000), d)
        $display("test frozen done");
        m = 12'($urandom);
        reg_write(FPSR_ADDR_MASK_SUP, {1'b1, m[6:0]});
        reg_write(FPSR_ADDR_MASK_INP, {3'b111, m[11:7]});
        reg_read(FPSR_ADDR_MASK_SUP, d);
        `CHK("mask sup", {1'b0, m[6:0]}, d)
        reg_read(FPSR_ADDR_MASK_INP, d);
        `CHK("mask inp", {3'b000, m[11:7]}, d)
        drive_plane(p ^ m);
        reg_read(FPSR_ADDR_PLANE_SUP, d);
        `CHK("masked dc", exp_dc(1'b0, p ^ m, m), d)
        drive_plane(p);
        reg_write(FPSR_ADDR_MASK_SUP, 8'h00);
        reg_write(FPSR_ADDR_MASK_INP, 8'h00);
        reg_read(FPSR_ADDR_PLANE_SUP, d);
        `CHK("unmasked dc", exp_dc(1'b0, p, 12'h000), d)
        $display("test mask done");
        for (int i = 0; i < 6; i++) begin
            @(negedge clock);
            uv_in = (i == 0) ? 7'h7F : 7'($urandom);
            ov_in = (i == 0) ? 7'h7F : 7'($urandom);
            det_in = (i == 0) ? 7'h7F : 7'($urandom);
            {wdog_in, gp_in} = (i == 0) ? 5'h1F : 5'($urandom);
            drv_in = (i == 0) ? 9'h1FF : 9'($urandom);
            repeat (8) @(negedge clock);
            foreach (STAT[k]) begin
                reg_read(STAT[k], d);
                `CHK("st", exp_stat(STAT[k]), d)
            end
        end
        reg_write(FPSR_ADDR_UV_STATUS, 8'hFF);
        reg_read(FPSR_ADDR_UV_STATUS, d);
        `CHK("read-only status", exp_stat(FPSR_ADDR_UV_STATUS), d)
        // read with no command byte: the pointer persists, and a host acknowledge
        // repeats the same register
        host.start();
        host.byte_w({DEV, 1'b1}, ack);
        host.byte_r(1'b1, d);
        host.byte_r(1'b0, dd);
        host.stop();
        `CHK("pointer read ack", 1'b1, ack)
        `CHK("repeat read", {2{exp_stat(FPSR_ADDR_UV_STATUS)}}, {d, dd})
        $display("test status done");
        host.start();
        host.byte_w({DEV ^ 7'h01, 1'b0}, ack);
        host.stop();
        `CHK("foreign address ack", 1'b0, ack)
        $display("test address done");
        complete_run();
    end
endmodule // tb_top

bind fpsr_regs fpsr_regs_asserts #(.SYNC_STAGES(SYNC_STAGES)) u_ast (
    .clock(clock), .rstn(rstn), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);
